/* File: srjid_pkg.sv */
// Shared constants and types for the SRAM test access port and its controller.
package srjid_pkg;

  // ==========================================================================
  // Instruction register
  // ==========================================================================
  localparam int unsigned IR_W = 3;
  typedef logic [IR_W-1:0] srjid_ir_t;

  localparam srjid_ir_t IR_EXTEST   = 3'h0;
  localparam srjid_ir_t IR_IDCODE   = 3'h1;
  localparam srjid_ir_t IR_SAMPLE_Z = 3'h2;
  localparam srjid_ir_t IR_RES_A    = 3'h3; // reserved_future_code
  localparam srjid_ir_t IR_SAMPLE   = 3'h4;
  localparam srjid_ir_t IR_PRIVATE  = 3'h5;
  localparam srjid_ir_t IR_RES_B    = 3'h6; // reserved_future_code
  localparam srjid_ir_t IR_BYPASS   = 3'h7;

  // Value parked in the instruction shifter on capture; low two bits are 01.
  localparam srjid_ir_t IR_CAPTURE  = 3'h1;

  // ==========================================================================
  // Data registers
  // ==========================================================================
  localparam int unsigned ID_W     = 32;
  localparam int unsigned BSR_LEN  = 8;
  localparam int unsigned BSR_PINS = 6;
  // Cells at and above BSR_PINS have no pin and capture their default.
  localparam logic [BSR_LEN-1:0] BSR_PIN_MASK = 8'h3f;
  localparam logic [BSR_LEN-1:0] BSR_DEFAULT  = 8'hc0;
  localparam logic               BYPASS_CAPT  = 1'h0;

  typedef enum logic [1:0] {
    SRJID_SEL_BYP,
    SRJID_SEL_ID,
    SRJID_SEL_BSR
  } srjid_sel_t;

  // ==========================================================================
  // TAP controller states
  // ==========================================================================
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
    TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } srjid_tap_t;

  // ==========================================================================
  // Controller timing
  // ==========================================================================
  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned TCK_MIN_NS = 50;
  // Eight clocks per test clock leaves room for the two-flop return path.
  localparam int unsigned TCK_DIV    = 8;
  localparam int unsigned TCK_HALF   = TCK_DIV / 2;
  localparam int unsigned RESET_TMS  = 5;
  localparam int unsigned CNT_W      = 6;
  localparam int unsigned PH_W       = 3;

  localparam logic [CNT_W-1:0] IRSEL_LAST = 6'h03;
  localparam logic [CNT_W-1:0] IR_LAST    = 6'h02;
  localparam logic [CNT_W-1:0] DRSEL_LAST = 6'h02;
  localparam logic [CNT_W-1:0] UPD_LAST   = 6'h01;
  localparam logic [CNT_W-1:0] RST_LAST   = 6'h04;
  localparam logic [3:0]       IRSEL_TMS  = 4'h3; // bit n is step n
  localparam logic [2:0]       DRSEL_TMS  = 3'h1;

  // Decode of the active instruction into the selected data register.
  function automatic srjid_sel_t srjid_decode(srjid_ir_t ir);
    case (ir)
      IR_EXTEST, IR_SAMPLE, IR_SAMPLE_Z: srjid_decode = SRJID_SEL_BSR;
      IR_IDCODE:                         srjid_decode = SRJID_SEL_ID;
      default:                           srjid_decode = SRJID_SEL_BYP;
    endcase
  endfunction : srjid_decode

endpackage : srjid_pkg

/* File: srjid_if.sv */
// Test access port wires between the SRAM end and the board controller.
`timescale 1ns/1ns
interface srjid_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // An undriven output line floats high through the board pull-up.
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe);
  modport host (output tck, output tms, output tdi, input tdo_line);
endinterface : srjid_if

/* File: srjid_sync.sv */
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ns
module srjid_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  // Register both stages.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end
endmodule : srjid_sync

/* File: srjid_device.sv */
// SRAM test access port: TAP controller, instruction decode, data registers.
// What this block does
// - Bypass code 111 shifts through one-bit bypass.
// - Sample/preload captures input and I/O pins.
// - Pinless cells capture their fixed default value.
// - Nothing holds RAM inputs stable during capture; a moving pin samples unrepeatably.
// - Nothing pauses the RAM clock, not even for ring capture.
// - Sample/preload shifts boundary register in Shift-DR.
// - All-zero instruction executes external test.
// - External test leaves RAM inputs live.
// - External test drives outputs from Update-IR falling.
// - External test captures pins in Capture-DR rising.
// - Each output drives its boundary cell value.
// - Identify loads ROM, shifts identification register.
// - Identify active at power-up and Test-Logic-Reset.
// - Code 010 floats outputs, shifts boundary register.
// - Reserved codes 011, 110 act as bypass.
// - Codes binary, most significant bit leftmost.
// - Three-bit instruction; capture loads low bits 01.
// - New instruction takes effect at Update-IR.
// - Sample inputs rising, change output falling.
// - Five high mode-select edges reach Test-Logic-Reset.
`timescale 1ns/1ns
module srjid_device #(
  // Identification value; arbitrary, bit 0 is the presence bit.
  parameter logic [srjid_pkg::ID_W-1:0] ID_ROM = 32'h0000_1001
) (
  // Power-up reset
  input  wire logic                           rst_n,
  // Test access port
  srjid_if.dev                                tap,
  // RAM pin levels, asynchronous to the test clock
  input  wire logic [srjid_pkg::BSR_PINS-1:0] pin_level,
  // Output driver control towards the RAM pads
  output logic      [srjid_pkg::BSR_PINS-1:0] pin_out_q,
  output logic                                pin_drive_q,
  output logic                                pin_hiz_q,
  output logic      [srjid_pkg::IR_W-1:0]     ir_active_q
);
  import srjid_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  srjid_tap_t                state_q;
  srjid_tap_t                state_d;
  srjid_ir_t                 ir_sh_q;
  srjid_ir_t                 ir_sh_d;
  logic                      byp_q;
  logic                      byp_d;
  logic [ID_W-1:0]           id_q;
  logic [ID_W-1:0]           id_d;
  logic [BSR_LEN-1:0]        bsr_q;
  logic [BSR_LEN-1:0]        bsr_d;
  logic [BSR_PINS-1:0]       pin_sync;
  logic [BSR_LEN-1:0]        ring;
  srjid_sel_t                sel_sh;
  srjid_ir_t                 ir_act_d;
  logic [BSR_PINS-1:0]       pin_out_d;
  logic                      pin_drive_d;
  logic                      pin_hiz_d;
  logic                      tdo_q;
  logic                      tdo_d;
  logic                      tdo_oe_q;
  logic                      tdo_oe_d;

  // ==========================================================================
  // Pin capture path
  // ==========================================================================
  // RAM pins toggle on the RAM clock, so they are resynchronised to the test
  // clock; a pin in transition still gives an unrepeatable sample.
  // capture window
  srjid_sync #(
    .W (BSR_PINS)
  ) u_pin_sync (
    .clk   (tap.tck),
    .rst_n (rst_n),
    .d     (pin_level),
    .q     (pin_sync)
  );

  // Pin cells take the pad level, pinless cells their default.
  // pinless defaults
  assign ring = ({{(BSR_LEN-BSR_PINS){1'b0}}, pin_sync} & BSR_PIN_MASK) |
                (BSR_DEFAULT & ~BSR_PIN_MASK);

  // Reserved and private codes fall to the bypass branch of the decoder.
  // reserved as bypass
  assign sel_sh = srjid_decode(ir_active_q);

  // ==========================================================================
  // TAP state machine, rising edge
  // ==========================================================================
  // Next state from mode select; five highs reach reset from anywhere.
  // mode-select reset
  always_comb begin
    case (state_q)
      TAP_RESET:    state_d = tap.tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:     state_d = tap.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   state_d = tap.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   state_d = tap.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:    state_d = tap.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR:   state_d = tap.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_d = tap.tms ? TAP_EX2_DR : TAP_PAUSE_DR;
      TAP_EX2_DR:   state_d = tap.tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR:   state_d = tap.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   state_d = tap.tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR:   state_d = tap.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:    state_d = tap.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR:   state_d = tap.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_d = tap.tms ? TAP_EX2_IR : TAP_PAUSE_IR;
      TAP_EX2_IR:   state_d = tap.tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR:   state_d = tap.tms ? TAP_SEL_DR : TAP_IDLE;
      default:      state_d = TAP_RESET;
    endcase
  end

  // Shift and capture of the instruction and data registers.
  always_comb begin
    ir_sh_d = ir_sh_q;
    byp_d   = byp_q;
    id_d    = id_q;
    bsr_d   = bsr_q;
    case (state_q)
      TAP_CAP_IR: ir_sh_d = IR_CAPTURE;
      // Least significant bit leaves first, so the code reads msb-left.
      // bit order
      TAP_SH_IR: ir_sh_d = {tap.tdi, ir_sh_q[IR_W-1:1]};
      TAP_CAP_DR: begin
        case (sel_sh)
          SRJID_SEL_BYP: byp_d = BYPASS_CAPT;
          SRJID_SEL_ID:  id_d  = ID_ROM;
          SRJID_SEL_BSR: bsr_d = ring;
          default:       byp_d = BYPASS_CAPT;
        endcase
      end
      TAP_SH_DR: begin
        case (sel_sh)
          SRJID_SEL_BYP: byp_d = tap.tdi;
          SRJID_SEL_ID:  id_d  = {tap.tdi, id_q[ID_W-1:1]};
          SRJID_SEL_BSR: bsr_d = {tap.tdi, bsr_q[BSR_LEN-1:1]};
          default:       byp_d = tap.tdi;
        endcase
      end
      default: ir_sh_d = ir_sh_q;
    endcase
  end

  // Register the rising-edge group.
  always_ff @(posedge tap.tck or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TAP_RESET;
      ir_sh_q <= IR_CAPTURE;
      byp_q   <= BYPASS_CAPT;
      id_q    <= '0;
      bsr_q   <= BSR_DEFAULT;
    end else begin
      state_q <= state_d;
      ir_sh_q <= ir_sh_d;
      byp_q   <= byp_d;
      id_q    <= id_d;
      bsr_q   <= bsr_d;
    end
  end

  // ==========================================================================
  // Falling edge: instruction update, pad control, serial output
  // ==========================================================================
  // The RAM core keeps following its own pins in every mode; this block only
  // steers the output drivers, never the input path.
  // inputs stay live
  always_comb begin
    ir_act_d = ir_active_q;
    pin_out_d = pin_out_q;
    tdo_d    = tdo_q;
    tdo_oe_d = 1'b0;
    if (state_q == TAP_RESET) begin
      ir_act_d = IR_IDCODE;
    end
    if (state_q == TAP_UPD_IR) begin
      ir_act_d = ir_sh_q;
    end
    // Preload under sample, or reload under external test, on Update-DR.
    if (state_q == TAP_UPD_DR &&
        (ir_active_q == IR_SAMPLE || ir_active_q == IR_EXTEST)) begin
      pin_out_d = bsr_q[BSR_PINS-1:0];
    end
    if (state_q == TAP_SH_IR) begin
      tdo_d    = ir_sh_q[0];
      tdo_oe_d = 1'b1;
    end else if (state_q == TAP_SH_DR) begin
      tdo_oe_d = 1'b1;
      case (sel_sh)
        SRJID_SEL_ID:  tdo_d = id_q[0];
        SRJID_SEL_BSR: tdo_d = bsr_q[0];
        default:       tdo_d = byp_q;
      endcase
    end
    pin_drive_d = (ir_act_d == IR_EXTEST);
    pin_hiz_d   = (ir_act_d == IR_SAMPLE_Z);
  end

  // Register the falling-edge group; the pads show the update latch.
  // cell drives pin
  always_ff @(negedge tap.tck or negedge rst_n) begin
    if (!rst_n) begin
      ir_active_q <= IR_IDCODE;
      pin_out_q   <= '0;
      pin_drive_q <= 1'b0;
      pin_hiz_q   <= 1'b0;
      tdo_q       <= 1'b0;
      tdo_oe_q    <= 1'b0;
    end else begin
      ir_active_q <= ir_act_d;
      pin_out_q   <= pin_out_d;
      pin_drive_q <= pin_drive_d;
      pin_hiz_q   <= pin_hiz_d;
      tdo_q       <= tdo_d;
      tdo_oe_q    <= tdo_oe_d;
    end
  end

  assign tap.tdo    = tdo_q;
  assign tap.tdo_oe = tdo_oe_q;

endmodule : srjid_device

/* File: srjid_host.sv */
// Board-side controller: makes the test clock and runs IR then DR scans.
`timescale 1ns/1ns
module srjid_host (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Test access port
  srjid_if.host                            tap,
  // Command
  input  wire logic                        cmd_valid,
  input  wire logic                        cmd_reset,
  input  wire logic [srjid_pkg::IR_W-1:0]  cmd_ir,
  input  wire logic [srjid_pkg::CNT_W-1:0] cmd_len,
  input  wire logic [srjid_pkg::ID_W-1:0]  cmd_data,
  output logic                             cmd_ready_q,
  // Response
  output logic                             rsp_valid_q,
  output logic      [srjid_pkg::IR_W-1:0]  rsp_ir_q,
  output logic      [srjid_pkg::ID_W-1:0]  rsp_data_q
);
  import srjid_pkg::*;

  typedef enum logic [2:0] {
    H_RST, H_IDLE, H_IRSEL, H_IRSH, H_IRUPD, H_DRSEL, H_DRSH, H_DRUPD
  } srjid_hst_t;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  srjid_hst_t        st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [PH_W-1:0]   ph_q, ph_d;
  logic              tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d;
  logic              pend_q, pend_d, rst_req_q, rst_req_d;
  srjid_ir_t         ir_q, ir_d;
  logic [CNT_W-1:0]  len_q, len_d;
  logic [ID_W-1:0]   data_q, data_d;
  logic              ready_d, valid_d;
  srjid_ir_t         rir_d;
  logic [ID_W-1:0]   rdata_d;
  logic              tdo_s;
  logic              fall, rise;

  // ==========================================================================
  // Returning serial data
  // ==========================================================================
  srjid_sync #(
    .W (1)
  ) u_tdo_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (tap.tdo_line),
    .q     (tdo_s)
  );

  // The test clock falls at the wrap and rises at mid period.
  assign fall = (ph_q == PH_W'(TCK_DIV - 1));
  assign rise = (ph_q == PH_W'(TCK_HALF - 1));

  // ==========================================================================
  // Step sequencer
  // ==========================================================================
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    ph_d      = fall ? '0 : ph_q + 1'b1;
    tck_d     = rise ? 1'b1 : (fall ? 1'b0 : tck_q);
    tms_d     = tms_q;
    tdi_d     = tdi_q;
    pend_d    = pend_q;
    rst_req_d = rst_req_q;
    ir_d      = ir_q;
    len_d     = len_q;
    data_d    = data_q;
    valid_d   = 1'b0;
    rir_d     = rsp_ir_q;
    rdata_d   = rsp_data_q;
    // Take a command while idle; it starts at the next falling edge.
    if (cmd_valid && cmd_ready_q) begin
      pend_d    = 1'b1;
      rst_req_d = cmd_reset;
      ir_d      = cmd_ir;
      len_d     = cmd_len;
      data_d    = cmd_data;
    end
    // Sample the device output at the rising edge of each shift step.
    if (rise && st_q == H_IRSH) begin
      rir_d[cnt_q[1:0]] = tdo_s;
    end
    if (rise && st_q == H_DRSH) begin
      rdata_d[cnt_q[4:0]] = tdo_s;
    end
    // Advance one step per test clock, at its falling edge.
    if (fall) begin
      cnt_d = cnt_q + 1'b1;
      case (st_q)
        H_RST: if (cnt_q == RST_LAST) begin
          st_d = H_IDLE;
        end
        H_IDLE: begin
          cnt_d = '0;
          if (pend_q) begin
            pend_d = 1'b0;
            st_d   = rst_req_q ? H_RST : H_IRSEL;
          end
        end
        H_IRSEL: if (cnt_q == IRSEL_LAST) begin
          st_d  = H_IRSH;
          cnt_d = '0;
        end
        H_IRSH: if (cnt_q == IR_LAST) begin
          st_d  = H_IRUPD;
          cnt_d = '0;
        end
        H_IRUPD: if (cnt_q == UPD_LAST) begin
          st_d  = H_DRSEL;
          cnt_d = '0;
        end
        H_DRSEL: if (cnt_q == DRSEL_LAST) begin
          st_d  = H_DRSH;
          cnt_d = '0;
        end
        H_DRSH: if (cnt_q == len_q - 1'b1) begin
          st_d  = H_DRUPD;
          cnt_d = '0;
        end
        H_DRUPD: if (cnt_q == UPD_LAST) begin
          st_d    = H_IDLE;
          valid_d = 1'b1;
        end
        default: st_d = H_IDLE;
      endcase
      // Pins for the new step change with the falling edge.
      // lsb shifted first
      case (st_d)
        H_RST:   tms_d = 1'b1;
        H_IRSEL: tms_d = IRSEL_TMS[cnt_d[1:0]];
        H_IRSH:  tms_d = (cnt_d == IR_LAST);
        H_DRSEL: tms_d = DRSEL_TMS[cnt_d[1:0]];
        H_DRSH:  tms_d = (cnt_d == len_q - 1'b1);
        H_IRUPD, H_DRUPD: tms_d = (cnt_d != UPD_LAST);
        default: tms_d = 1'b0;
      endcase
      case (st_d)
        H_IRSH:  tdi_d = ir_q[cnt_d[1:0]];
        H_DRSH:  tdi_d = data_q[cnt_d[4:0]];
        default: tdi_d = 1'b1;
      endcase
    end
    // Reserved and private codes are the caller's to avoid.
    // no reserved codes
    ready_d = (st_d == H_IDLE) && !pend_d;
  end

  // Register the sequencer; reset starts a five-high reset walk.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= H_RST;
      cnt_q <= '0;
      ph_q <= '0;
      tck_q <= 1'b0;
      tms_q <= 1'b1;
      tdi_q <= 1'b1;
      pend_q <= 1'b0;
      rst_req_q <= 1'b0;
      ir_q <= IR_BYPASS;
      len_q <= '0;
      data_q <= '0;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_ir_q <= '0;
      rsp_data_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      tck_q <= tck_d;
      tms_q <= tms_d;
      tdi_q <= tdi_d;
      pend_q <= pend_d;
      rst_req_q <= rst_req_d;
      ir_q <= ir_d;
      len_q <= len_d;
      data_q <= data_d;
      cmd_ready_q <= ready_d;
      rsp_valid_q <= valid_d;
      rsp_ir_q <= rir_d;
      rsp_data_q <= rdata_d;
    end
  end

  assign tap.tck = tck_q;
  assign tap.tms = tms_q;
  assign tap.tdi = tdi_q;

endmodule : srjid_host

/* File: srjid_monitor.sv */
// Concurrent checks on the test access port wires.
`timescale 1ns/1ns
module srjid_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link wires
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tdo_line
);
  // ==========================================================================
  // Link timing
  // ==========================================================================
  // clock high time
  tck_shape_a: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(tck) |-> tck[*4] ##1 !tck)
    else $error("test clock high time is not four clocks");
  tdo_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe))
    else $error("serial output moved while test clock high");
  tms_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    tck && $past(tck) |-> $stable(tms) && $stable(tdi))
    else $error("mode select or data moved while test clock high");
  reset_walk_a: assert property (
    @(posedge tck) disable iff (!rst_n) tms[*5] |-> ##1 !tdo_oe)
    else $error("output enabled after five mode select highs");
  shift_entry_a: assert property (
    @(posedge tck) disable iff (!rst_n) $rose(tdo_oe) |-> !$past(tms))
    else $error("shift entered without mode select low");
  shift_exit_a: assert property (
    @(posedge tck) disable iff (!rst_n) $fell(tdo_oe) |-> $past(tms))
    else $error("shift left without mode select high");
  line_fall_a: assert property (
    @(posedge clk) disable iff (!rst_n) $changed(tdo_line) |-> $fell(tck))
    else $error("serial line moved away from a test clock fall");
  quiet_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> !tdo_oe && !tck)
    else $error("link active at reset release");
endmodule : srjid_monitor

/* File: tb_top.sv */
// Bench joining the board controller to the SRAM test port.
`timescale 1ns/1ns
module tb_top;
  import srjid_pkg::*;
  // Identification value; arbitrary.
  localparam logic [31:0] TB_ID = 32'h0000_1001;
  logic        clk, rst_n, cmd_valid, cmd_reset, cmd_ready_q;
  logic        rsp_valid_q, pin_drive_q, pin_hiz_q;
  srjid_ir_t   cmd_ir, rsp_ir_q, ir_active_q;
  logic [5:0]  cmd_len, pin_level, pin_out_q;
  logic [31:0] cmd_data, rsp_data_q;
  logic [7:0]  ring;
  srjid_ir_t   byp [4] = '{IR_RES_A, IR_PRIVATE, IR_RES_B, IR_BYPASS};
  int          fails = 0;
  int          n_compared = 0;

  // ==========================================================================
  // Structure
  // ==========================================================================
  srjid_if tap_if ();
  srjid_device #(.ID_ROM(TB_ID)) srjid_device_inst (
    .rst_n(rst_n), .tap(tap_if.dev), .pin_level(pin_level),
    .pin_out_q(pin_out_q), .pin_drive_q(pin_drive_q),
    .pin_hiz_q(pin_hiz_q), .ir_active_q(ir_active_q));
  srjid_host srjid_host_inst (
    .clk(clk), .rst_n(rst_n), .tap(tap_if.host), .cmd_valid(cmd_valid),
    .cmd_reset(cmd_reset), .cmd_ir(cmd_ir), .cmd_len(cmd_len),
    .cmd_data(cmd_data), .cmd_ready_q(cmd_ready_q),
    .rsp_valid_q(rsp_valid_q), .rsp_ir_q(rsp_ir_q), .rsp_data_q(rsp_data_q));
  srjid_monitor srjid_monitor_inst (
    .clk(clk), .rst_n(rst_n), .tck(tap_if.tck), .tms(tap_if.tms),
    .tdi(tap_if.tdi), .tdo(tap_if.tdo), .tdo_oe(tap_if.tdo_oe),
    .tdo_line(tap_if.tdo_line));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Compare one value and count the outcome.
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Print counts and the verdict, then stop.
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // Bounded wait for a response pulse or for ready; sampled mid-cycle.
  task automatic wait_for(input bit on_rsp);
    int n;
    for (n = 0; n < 1000; n++) begin
      @(negedge clk);
      if (on_rsp ? rsp_valid_q === 1'b1 : cmd_ready_q === 1'b1) break;
    end
    if (n == 1000) begin
      fails++;
      report_and_stop();
    end
  endtask : wait_for

  // One command: instruction scan then data scan, or a reset walk.
  task automatic scan(srjid_ir_t ir, logic [5:0] len, logic [31:0] d,
                      logic rst);
    wait_for(1'b0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_reset <= rst;
    cmd_ir    <= ir;
    cmd_len   <= len;
    cmd_data  <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    if (!rst) wait_for(1'b1);
    wait_for(1'b0);
  endtask : scan

  // ==========================================================================
  // Stimulus
  // ==========================================================================
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Main sequence; expected ring is pins plus pinless defaults.
  initial begin
    rst_n     = 1'b0;
    cmd_valid = 1'b0;
    cmd_reset = 1'b0;
    cmd_ir    = 3'h0;
    cmd_len   = 6'h00;
    cmd_data  = 32'h0;
    pin_level = 6'h2d;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_for(1'b0);
    check("ir_reset", 32'(ir_active_q), 32'(IR_IDCODE));
    scan(IR_IDCODE, 6'd32, 32'h0, 1'b0);
    check("id_data", rsp_data_q, TB_ID);
    check("ir_capture", 32'(rsp_ir_q), 32'(IR_CAPTURE));
    foreach (byp[i]) begin
      scan(byp[i], 6'd2, 32'h1, 1'b0);
      check("bypass", 32'(rsp_data_q[1:0]), {31'h1, BYPASS_CAPT});
      check("ir_active", 32'(ir_active_q), 32'(byp[i]));
      check("drive_off", 32'(pin_drive_q), 32'h0);
    end
    ring = BSR_DEFAULT | ({2'b00, pin_level} & BSR_PIN_MASK);
    scan(IR_SAMPLE, 6'd8, 32'h15, 1'b0);
    check("sample_ring", 32'(rsp_data_q[7:0]), 32'(ring));
    check("preload", 32'(pin_out_q), 32'h15);
    @(posedge clk) pin_level <= 6'h12;
    ring = BSR_DEFAULT | 8'h12;
    scan(IR_EXTEST, 6'd8, 32'h2a, 1'b0);
    check("extest_drive", 32'(pin_drive_q), 32'h1);
    check("extest_ring", 32'(rsp_data_q[7:0]), 32'(ring));
    check("extest_out", 32'(pin_out_q), 32'h2a);
    @(posedge clk) pin_level <= 6'h0c;
    ring = BSR_DEFAULT | 8'h0c;
    scan(IR_EXTEST, 6'd8, 32'h2a, 1'b0);
    check("extest_live", 32'(rsp_data_q[7:0]), 32'(ring));
    scan(IR_SAMPLE_Z, 6'd8, 32'h0, 1'b0);
    check("hiz_on", 32'({pin_hiz_q, pin_drive_q}), 32'h2);
    check("hiz_ring", 32'(rsp_data_q[7:0]), 32'(ring));
    scan(IR_BYPASS, 6'd1, 32'h0, 1'b1);
    check("walk_reset", 32'(ir_active_q), 32'(IR_IDCODE));
    check("hiz_off", 32'(pin_hiz_q), 32'h0);
    report_and_stop();
  end
endmodule : tb_top
